// ---- logic/wphs_pcs.sv ----
// What this block does
// - 32-bit MAC words, octet-wide PMA path
// - insert two header check octets after delimiter
// - scramble octets after check field to end
// - send octet only after PMA ready
// - wait-hold throttles MAC word intake
// - take PMA octet only when enabled
// - pad word when no full receive word
// - packet held back at least ten octets
// - received check octets never reach MAC
// - bit order reversed at PMA side
// - descrambler idle in search and tentative
// - locked descrambler runs on packet body only
// - scrambler seeded at reset, descrambler cleared
// - paused scrambler state held unchanged
// - 43-bit register, output xor bit 43 back
// - octets scrambled least significant bit first
// - packet entering lock lost while descrambler synchronises
// - check covers first eight packet octets
// - correcting mode fixes single-bit errors only
// - correcting mode set on entering lock
// - search per octet, tentative per packet
// - uncorrectable error in lock returns search
// - check is CRC-16 xor fixed pattern
// - length in first two octets finds next
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wphs_pcs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire wphs_pkg::wphs_mac_s mac_tx,
  output logic mac_tx_wait_hold,
  output logic [7:0] lower_octet_send,
  output logic tx_octet_valid,
  input wire logic tx_octet_rdy,
  input wire logic [7:0] lower_octet_receive,
  input wire logic rx_octet_en,
  input wire logic rx_signal_lost,
  output var wphs_pkg::wphs_mac_s mac_rx
);
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < wphs_pkg::OCT_W; i++)
      r[i] = v[wphs_pkg::OCT_W-1-i];
    return r;
  endfunction

  function automatic logic [15:0] crc_hdr(input logic [63:0] h);
    logic [15:0] c;
    logic fb;
    c = '0;
    for (int i = 0; i < wphs_pkg::HDR_OCT * wphs_pkg::OCT_W; i++)
    begin
      fb = c[15] ^ h[i];
      c = {c[14:0], 1'b0} ^ (fb ? wphs_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // running check remainder, one octet fed lsb first
  function automatic logic [15:0] crc_oct(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < wphs_pkg::OCT_W; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? wphs_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // returns {next state, output octet}; de selects descrambling
  function automatic logic [50:0] scr_oct(input logic [42:0] s, input logic [7:0] o, input logic de);
    logic [7:0] r;
    for (int i = 0; i < wphs_pkg::OCT_W; i++)
    begin
      r[i] = o[i] ^ s[wphs_pkg::SCR_LEN-1];
      s = {s[41:0], de ? o[i] : r[i]};
    end
    return {s, r};
  endfunction

  wphs_pkg::wphs_tx_e tst;
  wphs_pkg::wphs_dl_e dst;
  wphs_pkg::wphs_mode_e mode;
  wphs_pkg::wphs_mac_s txw;
  wphs_pkg::wphs_mac_s pw;
  logic full, step, send, lane_c;
  logic [1:0] lane, alane, oseq;
  logic [7:0] lane_d, tx_val;
  logic [2:0] tcnt;
  logic [15:0] tcrc, thec;
  logic [42:0] scr, dsc;
  logic [50:0] scr_r, dsc_r;
  logic [79:0] wv, nwv;
  logic [7:0] rx_in;
  logic [63:0] fix, chdr, pre;
  logic [15:0] syn, plen;
  logic hit, good, fixable, acc, chk, pay, last, start_pkt;
  logic [16:0] cnt;
  logic [3:0] mcnt, delta;
  logic [31:0] asm_w;
  logic pkt_on, prdy, term_due;
  logic [15:0] n_cor, n_drop;
  logic a_we;
  logic [7:0] a_addr;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // hold while the word is still being split
  assign mac_tx_wait_hold = full && !(step && lane == 2'(wphs_pkg::LANES-1));
  assign lane_c = txw.ctrl[lane];
  assign lane_d = txw.data[{lane, 3'b000} +: 8];
  // data octets outside idle advance only on PMA ready; nothing advances during the check field, and control and idle-state octets otherwise do not wait
  assign step = full && tst != wphs_pkg::T_HEC && (lane_c || tst == wphs_pkg::T_IDLE || tx_octet_rdy);
  assign send = (tst == wphs_pkg::T_HEC && tx_octet_rdy)
    || (step && !lane_c && (tst == wphs_pkg::T_HDR || tst == wphs_pkg::T_BODY));
  assign thec = tcrc ^ wphs_pkg::HEC_XOR;
  assign scr_r = scr_oct(scr, lane_d, 1'b0);

  always_comb
  begin
    tx_val = lane_d;
    if (tst == wphs_pkg::T_HEC)
      tx_val = tcnt[0] ? rev8(thec[7:0]) : rev8(thec[15:8]);
    else if (tst == wphs_pkg::T_BODY)
      tx_val = scr_r[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      full <= 1'b0;
      lane <= '0;
      txw <= '0;
    end
    else if (!mac_tx_wait_hold)
    begin
      full <= 1'b1;
      lane <= '0;
      txw <= mac_tx;
    end
    else if (step)
      lane <= 2'(lane + 2'h1);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tst <= wphs_pkg::T_IDLE;
      tcnt <= '0;
      tcrc <= '0;
    end
    else
      case (tst)
        wphs_pkg::T_IDLE:
          if (step && lane_c && lane_d == wphs_pkg::C_START)
          begin
            tst <= wphs_pkg::T_HDR;
            tcnt <= '0;
            tcrc <= '0;
          end
        wphs_pkg::T_HDR:
          if (step && lane_c && lane_d == wphs_pkg::C_TERM)
            tst <= wphs_pkg::T_IDLE;
          else if (step && !lane_c)
          begin
            tcrc <= crc_oct(tcrc, lane_d);
            tcnt <= 3'(tcnt + 3'h1);
            if (tcnt == 3'(wphs_pkg::HDR_OCT-1))
            begin
              tst <= wphs_pkg::T_HEC;
              tcnt <= '0;
            end
          end
        wphs_pkg::T_HEC:
          if (tx_octet_rdy)
          begin
            tcnt <= 3'(tcnt + 3'h1);
            if (tcnt == 3'(wphs_pkg::HEC_OCT-1))
              tst <= wphs_pkg::T_BODY;
          end
        wphs_pkg::T_BODY:
          if (step && lane_c && lane_d == wphs_pkg::C_TERM)
            tst <= wphs_pkg::T_IDLE;
        default:
          tst <= wphs_pkg::T_IDLE;
      endcase

  // seeded, advances only on body octets
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      scr <= wphs_pkg::SCR_SEED;
    else if (send && tst == wphs_pkg::T_BODY)
      scr <= scr_r[50:8];

  // line bit order reversed on send
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      lower_octet_send <= '0;
      tx_octet_valid <= 1'b0;
    end
    else
    begin
      tx_octet_valid <= send;
      if (send)
        lower_octet_send <= rev8(tx_val);
    end

  assign acc = rx_octet_en;
  assign rx_in = rev8(lower_octet_receive);
  assign nwv = {rx_in, wv[79:8]};
  assign syn = crc_hdr(nwv[63:0]) ^ wphs_pkg::HEC_XOR ^ {rev8(nwv[71:64]), rev8(nwv[79:72])};
  assign good = syn == 16'h0000;

  always_comb
  begin
    fix = '0;
    hit = 1'b0;
    for (int i = 0; i < wphs_pkg::HDR_OCT * wphs_pkg::OCT_W; i++)
      if (crc_hdr(64'h1 << i) == syn)
      begin
        fix = 64'h1 << i;
        hit = 1'b1;
      end
  end
  assign fixable = mode == wphs_pkg::M_CORRECT && !good && (hit || $countones(syn) == 1);
  assign chdr = nwv[63:0] ^ fix;
  assign plen = {chdr[7:0], chdr[15:8]};
  assign chk = dst == wphs_pkg::D_SEARCH || cnt == wphs_pkg::CNT_ONE;
  assign pay = dst != wphs_pkg::D_SEARCH && cnt > 17'(wphs_pkg::WIN_OCT);
  assign last = pkt_on && acc && pay && cnt == 17'(wphs_pkg::WIN_OCT + 1);
  assign start_pkt = acc && chk && dst == wphs_pkg::D_LOCK && (good || fixable)
    && chdr[63:56] != wphs_pkg::SFD_IDLE_PKT;
  assign dsc_r = scr_oct(dsc, rx_in, 1'b1);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wv <= '0;
    else if (acc)
      wv <= nwv;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dst <= wphs_pkg::D_SEARCH;
      mode <= wphs_pkg::M_CORRECT;
      mcnt <= '0;
      cnt <= '0;
    end
    else if (rx_signal_lost)
    begin
      dst <= wphs_pkg::D_SEARCH;
      mode <= wphs_pkg::M_CORRECT;
    end
    else if (acc && chk)
    begin
      cnt <= 17'(plen) + 17'(wphs_pkg::WIN_OCT);
      mcnt <= 4'(mcnt + 4'h1);
      case (dst)
        wphs_pkg::D_SEARCH:
          if (good)
          begin
            dst <= wphs_pkg::D_TENT;
            mcnt <= '0;
          end
        wphs_pkg::D_TENT:
          if (!good)
            dst <= wphs_pkg::D_SEARCH;
          else if (4'(mcnt + 4'h1) >= delta)
          begin
            dst <= wphs_pkg::D_LOCK;
            mode <= wphs_pkg::M_CORRECT;
          end
        default:
          if (good)
            mode <= wphs_pkg::M_CORRECT;
          else if (fixable)
            mode <= wphs_pkg::M_DETECT;
          else
          begin
            dst <= wphs_pkg::D_SEARCH;
            mode <= wphs_pkg::M_CORRECT;
          end
      endcase
    end
    else if (acc && dst != wphs_pkg::D_SEARCH)
      cnt <= 17'(cnt - wphs_pkg::CNT_ONE);

  // descrambler runs only in lock body
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dsc <= '0;
    else if (acc && pay && dst == wphs_pkg::D_LOCK)
      dsc <= dsc_r[50:8];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pre <= '0;
      oseq <= '0;
    end
    else if (start_pkt)
    begin
      pre <= chdr;
      oseq <= 2'h1;
    end
    else if (oseq != 2'h0)
      oseq <= 2'(oseq + 2'h1);

  // packing into words; a short last word is padded
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      asm_w <= '0;
      alane <= '0;
      pw <= '0;
      prdy <= 1'b0;
    end
    else
    begin
      // a word is shown once; a word completed in the same cycle wins
      if (oseq == 2'h0 && prdy)
        prdy <= 1'b0;
      if (pkt_on && acc && pay)
      begin
        asm_w[{alane, 3'b000} +: 8] <= dsc_r[7:0];
        alane <= 2'(alane + 2'h1);
        if (alane == 2'(wphs_pkg::LANES-1) || last)
        begin
          for (int l = 0; l < wphs_pkg::LANES; l++)
          begin
            pw.ctrl[l] <= l > alane;
            pw.data[l*8 +: 8] <= l < alane ? asm_w[l*8 +: 8] : (l == alane ? dsc_r[7:0] : wphs_pkg::C_PAD);
          end
          prdy <= 1'b1;
          alane <= '0;
        end
      end
      if (start_pkt)
        alane <= '0;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pkt_on <= 1'b0;
      term_due <= 1'b0;
    end
    else if (start_pkt)
    begin
      pkt_on <= 1'b1;
      term_due <= plen == 16'h0000;
    end
    // a lost lock ends the packet early
    else if (last || (pkt_on && dst == wphs_pkg::D_SEARCH))
      term_due <= 1'b1;
    else if (term_due && oseq == 2'h0 && !prdy)
    begin
      term_due <= 1'b0;
      pkt_on <= 1'b0;
    end

  // word output, pad when nothing ready
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_ALL, data: {4{wphs_pkg::C_IDLE}}};
    else if (oseq == 2'h1)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_ALL, data: {4{wphs_pkg::C_START}}};
    else if (oseq == 2'h2)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_NONE, data: pre[31:0]};
    else if (oseq == 2'h3)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_NONE, data: pre[63:32]};
    else if (prdy)
      mac_rx <= pw;
    else if (term_due)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_ALL, data: {4{wphs_pkg::C_TERM}}};
    else if (pkt_on)
      mac_rx <= '{ctrl: wphs_pkg::CTRL_ALL, data: {4{wphs_pkg::C_PAD}}};
    else
      mac_rx <= '{ctrl: wphs_pkg::CTRL_ALL, data: {4{wphs_pkg::C_IDLE}}};

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      a_we <= 1'b0;
      a_addr <= '0;
      hrdata <= '0;
    end
    else
    begin
      a_we <= hsel && htrans[1] && hready && hwrite;
      a_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        if (haddr[7:0] == wphs_pkg::A_CTRL)
          hrdata <= {28'h0, delta};
        else if (haddr[7:0] == wphs_pkg::A_STAT)
          hrdata <= {28'h0, tst != wphs_pkg::T_IDLE, mode, dst};
        else if (haddr[7:0] == wphs_pkg::A_ERR)
          hrdata <= {n_drop, n_cor};
        else
          hrdata <= '0;
      end
    end

  // counters saturate; a count in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      delta <= wphs_pkg::DELTA_RST;
      n_cor <= '0;
      n_drop <= '0;
    end
    else
    begin
      if (a_we && a_addr == wphs_pkg::A_CTRL)
        delta <= hwdata[3:0];
      if (a_we && a_addr == wphs_pkg::A_ERR)
      begin
        n_cor <= {15'h0, acc && chk && dst == wphs_pkg::D_LOCK && fixable};
        n_drop <= {15'h0, acc && chk && dst == wphs_pkg::D_LOCK && !good && !fixable};
      end
      else
      begin
        if (acc && chk && dst == wphs_pkg::D_LOCK && fixable && n_cor != 16'hffff)
          n_cor <= 16'(n_cor + 16'h1);
        if (acc && chk && dst == wphs_pkg::D_LOCK && !good && !fixable && n_drop != 16'hffff)
          n_drop <= 16'(n_drop + 16'h1);
      end
    end

  sequence hdr_done;
    tst == wphs_pkg::T_HDR && step && !lane_c && tcnt == 3'(wphs_pkg::HDR_OCT-1);
  endsequence
  sequence lock_entry;
    dst == wphs_pkg::D_TENT ##1 dst == wphs_pkg::D_LOCK;
  endsequence

  AST_TX_RDY: assert property (tx_octet_valid |-> $past(tx_octet_rdy))
    else $error("octet sent without ready");
  AST_HEC_POS: assert property (hdr_done |=> tst == wphs_pkg::T_HEC ##0 tcnt == 3'h0)
    else $error("check field not after header");
  AST_HDR_CLEAR: assert property (tst == wphs_pkg::T_HDR && send |=> lower_octet_send == rev8($past(lane_d)))
    else $error("header octet altered");
  AST_SCR_HOLD: assert property (!(send && tst == wphs_pkg::T_BODY) |=> $stable(scr))
    else $error("scrambler moved while paused");
  AST_RX_EN: assert property (!rx_octet_en |=> $stable(wv))
    else $error("octet taken without enable");
  AST_DSC_OFF: assert property (dst != wphs_pkg::D_LOCK |=> $stable(dsc))
    else $error("descrambler ran out of lock");
  AST_LOCK_MODE: assert property (lock_entry |-> mode == wphs_pkg::M_CORRECT)
    else $error("lock entered without correcting mode");
  AST_LOST: assert property (acc && chk && dst == wphs_pkg::D_LOCK && !good && !fixable && !rx_signal_lost
    |=> dst == wphs_pkg::D_SEARCH)
    else $error("bad check did not drop lock");
  AST_PAD: assert property (pkt_on && oseq == 2'h0 && !prdy && !term_due && !start_pkt
    |=> mac_rx.data == {4{wphs_pkg::C_PAD}} && mac_rx.ctrl == wphs_pkg::CTRL_ALL)
    else $error("no pad word in packet gap");
  AST_START_SEQ: assert property (start_pkt |-> ##2 mac_rx.data == {4{wphs_pkg::C_START}}
    ##1 mac_rx.data == $past(chdr[31:0], 3))
    else $error("packet start sequence wrong");
endmodule
`default_nettype wire

// ---- logic/wphs_pkg.sv ----
`default_nettype none
package wphs_pkg;
  localparam int OCT_W = 8;
  localparam int LANES = 4;
  localparam int HDR_OCT = 8;
  localparam int HEC_OCT = 2;
  localparam int WIN_OCT = 10;
  localparam int SCR_LEN = 43;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] HEC_XOR = 16'h1555;
  localparam logic [7:0] C_IDLE = 8'h07;
  localparam logic [7:0] C_START = 8'hfb;
  localparam logic [7:0] C_TERM = 8'hfd;
  localparam logic [7:0] C_PAD = 8'h9c;
  localparam logic [7:0] SFD_IDLE_PKT = 8'h00;
  localparam logic [3:0] CTRL_ALL = 4'hf;
  localparam logic [3:0] CTRL_NONE = 4'h0;
  // power-on scrambler state; value arbitrary
  localparam logic [42:0] SCR_SEED = 43'h2a55a5ac3e1;
  localparam logic [3:0] DELTA_RST = 4'h1;
  localparam logic [16:0] CNT_ONE = 17'h00001;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ERR = 8'h08;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [31:0] data;
  } wphs_mac_s;
  typedef enum logic [1:0] {T_IDLE, T_HDR, T_HEC, T_BODY} wphs_tx_e;
  typedef enum logic [1:0] {D_SEARCH, D_TENT, D_LOCK} wphs_dl_e;
  typedef enum logic {M_CORRECT, M_DETECT} wphs_mode_e;
endpackage
`default_nettype wire

// ---- tb/wphs_pma_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wphs_pma_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] pace,
  input wire logic [31:0] err_idx,
  input wire logic [7:0] err_mask,
  input wire logic [7:0] lower_octet_send,
  input wire logic tx_octet_valid,
  output logic tx_octet_rdy,
  output logic [7:0] lower_octet_receive,
  output logic rx_octet_en
);
  logic [1:0] slot;
  logic [31:0] oct_cnt;
  // octet pacing
  // one slot in four is lost to framing overhead, slow pace keeps one in four
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      slot <= 2'h0;
      tx_octet_rdy <= 1'b0;
    end
    else
    begin
      slot <= slot + 2'h1;
      tx_octet_rdy <= (pace == 2'h0) ? (slot != 2'h3) : (pace == 2'h1) ? (slot == 2'h0) : 1'b0;
    end
  // octet loopback
  // outside enabled cycles the line inverts every cycle, showing the last octet again every second cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      oct_cnt <= 32'h0;
      rx_octet_en <= 1'b0;
      lower_octet_receive <= 8'h00;
    end
    else
    begin
      rx_octet_en <= tx_octet_valid;
      if (tx_octet_valid)
      begin
        lower_octet_receive <= (oct_cnt == err_idx) ? lower_octet_send ^ err_mask : lower_octet_send;
        oct_cnt <= oct_cnt + 32'h1;
      end
      else
        lower_octet_receive <= ~lower_octet_receive;
    end
endmodule
`default_nettype wire

// ---- tb/wphs_pcs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module wphs_pcs_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_octet_rdy, tx_octet_valid;
  logic rx_octet_en, rx_signal_lost, mac_tx_wait_hold, rdy_q, in_pkt;
  logic [1:0] htrans, pace;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, err_idx;
  logic [7:0] lower_octet_send, lower_octet_receive, err_mask, v, e, oc;
  logic [42:0] hist;
  wphs_pkg::wphs_mac_s mac_tx, mac_rx;
  logic [7:0] exp_q[$], last_sent[$], rx_cur[$], rx_last[$];
  logic [15:0] hec_q[$];
  int len_q[$];
  int n_mismatch, n_checks, rx_cnt, tot, tx_pos, nsc, n_tx, n, m;

  wphs_pcs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mac_tx(mac_tx), .mac_tx_wait_hold(mac_tx_wait_hold),
    .lower_octet_send(lower_octet_send), .tx_octet_valid(tx_octet_valid), .tx_octet_rdy(tx_octet_rdy),
    .lower_octet_receive(lower_octet_receive), .rx_octet_en(rx_octet_en),
    .rx_signal_lost(rx_signal_lost), .mac_rx(mac_rx));
  wphs_pma_model i_pma (.hclk(hclk), .hresetn(hresetn), .pace(pace), .err_idx(err_idx),
    .err_mask(err_mask), .lower_octet_send(lower_octet_send), .tx_octet_valid(tx_octet_valid),
    .tx_octet_rdy(tx_octet_rdy), .lower_octet_receive(lower_octet_receive), .rx_octet_en(rx_octet_en));

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, g, x);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] a);
    for (int i = 0; i < 8; i++)
      rev8[i] = a[7 - i];
  endfunction

  // bit-serial remainder, first octet lsb first, then the fixed pattern
  function automatic logic [15:0] hec_of(input logic [63:0] hb);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 64; i++)
      c = {c[14:0], 1'b0} ^ ((hb[i] ^ c[15]) ? wphs_pkg::CRC_POLY : 16'h0000);
    return c ^ wphs_pkg::HEC_XOR;
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] x, input string s);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd & mk, x, s);
  endtask

  task automatic poll(input logic [31:0] mk, input logic [31:0] x, input string s);
    int i;
    i = 0;
    ahb(1'b0, wphs_pkg::A_STAT, 32'h0, rd);
    while ((rd & mk) !== x && i < 500)
    begin
      ahb(1'b0, wphs_pkg::A_STAT, 32'h0, rd);
      i++;
    end
    chk(rd & mk, x, s);
  endtask

  // word is taken at the edge where hold is low, so it stands until then
  task automatic put_word(input logic [3:0] c, input logic [31:0] d);
    mac_tx <= {c, d};
    @(posedge hclk);
    while (mac_tx_wait_hold !== 1'b0)
      @(posedge hclk);
  endtask

  task automatic send_pkt(input int len, input logic [7:0] s, input logic [7:0] em);
    logic [7:0] lo[$];
    logic lc[$];
    logic [63:0] hb;
    logic [3:0] c;
    logic [31:0] d;
    // length leads the header, high octet first
    hb = {8'hd5, {5{8'h55}}, len[7:0], len[15:8]};
    last_sent.delete();
    lo.push_back(wphs_pkg::C_START);
    lc.push_back(1'b1);
    for (int i = 0; i < 8 + len; i++)
    begin
      d[7:0] = (i < 8) ? hb[8 * i +: 8] : 8'(s + i);
      lo.push_back(d[7:0]);
      lc.push_back(1'b0);
      exp_q.push_back(d[7:0]);
      last_sent.push_back(d[7:0]);
    end
    lo.push_back(wphs_pkg::C_TERM);
    lc.push_back(1'b1);
    while (lo.size() % 4 != 0)
    begin
      lo.push_back(wphs_pkg::C_IDLE);
      lc.push_back(1'b1);
    end
    hec_q.push_back(hec_of(hb));
    len_q.push_back(len);
    err_idx <= tot + 3;
    err_mask <= em;
    tot += 10 + len;
    for (int w = 0; w < lo.size() / 4; w++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        d[8 * j +: 8] = lo[4 * w + j];
        c[j] = lc[4 * w + j];
      end
      put_word(c, d);
      if (w == 0)
        put_word(wphs_pkg::CTRL_ALL, {4{wphs_pkg::C_PAD}});
    end
    put_word(wphs_pkg::CTRL_ALL, {4{wphs_pkg::C_IDLE}});
  endtask

  task automatic wait_rx(input int k);
    int i;
    i = 0;
    while (rx_cnt < k && i < 3000)
    begin
      @(posedge hclk);
      i++;
    end
    chk(32'(rx_cnt >= k), 32'h1, "packet delivered");
  endtask

  task automatic chk_rx();
    logic ok;
    ok = (rx_last.size() == last_sent.size());
    foreach (last_sent[i])
      if (ok && rx_last[i] !== last_sent[i])
        ok = 1'b0;
    chk({31'h0, ok}, 32'h1, "received packet differs");
  endtask

  always @(posedge hclk)
  begin
    if (tx_octet_valid === 1'b1)
    begin
      n_tx++;
      chk({31'h0, rdy_q}, 32'h1, "octet without ready");
      v = rev8(lower_octet_send);
      if (tx_pos < 8)
        chk({24'h0, v}, {24'h0, exp_q.pop_front()}, "header octet");
      else if (tx_pos < 10)
        chk({24'h0, lower_octet_send}, {24'h0, tx_pos == 8 ? hec_q[0][15:8] : hec_q[0][7:0]}, "check octet");
      else
      begin
        e = exp_q.pop_front();
        // self-synchronous: each bit is the clear bit xor the output 43 bits back
        for (int b = 0; b < 8; b++)
        begin
          if (nsc >= 43)
            chk({31'h0, v[b]}, {31'h0, e[b] ^ hist[42]}, "scrambled bit");
          hist = {hist[41:0], v[b]};
          nsc++;
        end
      end
      if (tx_pos == 9)
        void'(hec_q.pop_front());
      tx_pos++;
      if (tx_pos == 10 + len_q[0])
      begin
        tx_pos = 0;
        void'(len_q.pop_front());
      end
    end
    rdy_q = tx_octet_rdy;
  end

  always @(posedge hclk)
    for (int i = 0; i < 4; i++)
    begin
      oc = mac_rx.data[8 * i +: 8];
      if (mac_rx.ctrl[i] === 1'b0 && in_pkt)
        rx_cur.push_back(oc);
      else if (mac_rx.ctrl[i] === 1'b1 && oc === wphs_pkg::C_START)
      begin
        in_pkt = 1'b1;
        rx_cur.delete();
      end
      else if (mac_rx.ctrl[i] === 1'b1 && oc === wphs_pkg::C_TERM && in_pkt)
      begin
        in_pkt = 1'b0;
        rx_last = rx_cur;
        rx_cnt++;
      end
    end

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    {hresetn, hsel, hwrite, rx_signal_lost, rdy_q, in_pkt} = 6'h0;
    {htrans, pace, haddr, hwdata, err_mask} = '0;
    hsize = 3'b010;
    err_idx = 32'hffffffff;
    hist = '0;
    mac_tx = {wphs_pkg::CTRL_ALL, {4{wphs_pkg::C_IDLE}}};
    {n_mismatch, n_checks, rx_cnt, tot, tx_pos, nsc, n_tx} = '0;
    repeat (4) @(posedge hclk);
    chk({28'h0, mac_rx.ctrl}, 32'hf, "idle word in reset");
    chk({31'h0, tx_octet_valid}, 32'h0, "no octet in reset");
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk({31'h0, mac_tx_wait_hold}, 32'h0, "hold after reset");
    chk({31'h0, hresp}, 32'h0, "okay response");
    rd_chk(wphs_pkg::A_CTRL, 32'hf, 32'h1, "delta at reset");
    rd_chk(wphs_pkg::A_STAT, 32'h7, 32'h0, "search and correcting");
    ahb(1'b1, 8'h0c, 32'hffffffff, rd);
    rd_chk(8'h0c, 32'hffffffff, 32'h0, "unmapped reads zero");
    ahb(1'b1, wphs_pkg::A_CTRL, 32'h1, rd);
    $display("test reset and registers done");
    for (int p = 0; p < 3; p++)
      send_pkt(16 + p, 8'(p), 8'h00);
    poll(32'h7, 32'h2, "locked and correcting");
    // the packet behind the lock is still draining
    repeat (20) @(posedge hclk);
    n = rx_cnt;
    send_pkt(21, 8'h40, 8'h00);
    wait_rx(n + 1);
    chk_rx();
    $display("test lock and delivery done");
    pace <= 2'd2;
    n = rx_cnt;
    fork
      send_pkt(30, 8'h80, 8'h00);
      begin
        repeat (10) @(posedge hclk);
        m = n_tx;
        repeat (40) @(posedge hclk);
        chk(n_tx, m, "octets while stalled");
        chk({31'h0, mac_tx_wait_hold}, 32'h1, "hold while stalled");
        pace <= 2'd1;
      end
    join
    wait_rx(n + 1);
    chk_rx();
    pace <= 2'd0;
    $display("test stall and slow pacing done");
    n = rx_cnt;
    send_pkt(20, 8'hc0, 8'h01);
    wait_rx(n + 1);
    chk_rx();
    rd_chk(wphs_pkg::A_ERR, 32'hffff, 32'h1, "corrected count");
    n = rx_cnt;
    send_pkt(20, 8'hd0, 8'h00);
    wait_rx(n + 1);
    chk_rx();
    send_pkt(20, 8'he0, 8'h03);
    poll(32'h3, 32'h0, "search after double error");
    rd_chk(wphs_pkg::A_ERR, 32'hffff0000, 32'h00010000, "uncorrected count");
    $display("test header errors done");
    for (int p = 0; p < 3; p++)
      send_pkt(24, 8'(16 * p), 8'h00);
    poll(32'h3, 32'h2, "relocked");
    rx_signal_lost <= 1'b1;
    @(posedge hclk);
    rx_signal_lost <= 1'b0;
    rd_chk(wphs_pkg::A_STAT, 32'h7, 32'h0, "search after signal loss");
    $display("test signal loss done");
    test_done();
  end
endmodule
`default_nettype wire
